// *** design/acrb_pkg.sv ***
// Package for the converter configuration register bank
package acrb_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 11;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned PAT_W = 12;
   // Register addresses
   localparam logic [4:0] ADDR_PWR = 5'h00;
   localparam logic [4:0] ADDR_CLKG = 5'h04;
   localparam logic [4:0] ADDR_TPAT = 5'h0a;
   localparam logic [4:0] ADDR_CPLO = 5'h0b;
   localparam logic [4:0] ADDR_CPHI = 5'h0c;
   // Reset value shared by every register
   localparam logic [10:0] REG_RST = 11'h000;
   // Field positions
   localparam int unsigned PWR_GLOBAL_BIT = 0;
   localparam int unsigned PWR_CH_LSB = 1;
   localparam int unsigned PWR_REF_BIT = 5;
   localparam int unsigned PWR_SWRST_BIT = 10;
   localparam int unsigned CLKG_LSB = 2;
   localparam int unsigned TPAT_SEL_LSB = 5;
   localparam int unsigned TPAT_FMT_BIT = 9;
   localparam int unsigned CPHI_MSB_BIT = 0;
   localparam int unsigned CPHI_FG_LSB = 8;
   // Writable bit masks; everything else is reserved and held at zero
   localparam logic [10:0] MASK_PWR = 11'h43f;
   localparam logic [10:0] MASK_CLKG = 11'h07c;
   localparam logic [10:0] MASK_TPAT = 11'h2e0;
   localparam logic [10:0] MASK_CPLO = 11'h7ff;
   localparam logic [10:0] MASK_CPHI = 11'h701;
   // Clock buffer gain codes
   localparam logic [4:0] CLKG_STEP0 = 5'h18;
   localparam logic [4:0] CLKG_STEP1 = 5'h00;
   localparam logic [4:0] CLKG_STEP2 = 5'h0c;
   localparam logic [4:0] CLKG_STEP3 = 5'h0a;
   localparam logic [4:0] CLKG_STEP4 = 5'h09;
   localparam logic [4:0] CLKG_STEP5 = 5'h08;
   // Fine gain limit
   localparam logic [2:0] FG_MAX = 3'h6;
   // Write settle time after the sixteenth serial clock
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned SETTLE_NS = 100;
   localparam int unsigned SETTLE_CYC_RAW = (SETTLE_NS * (CLK_HZ / 1000000)) / 1000;
   localparam int unsigned SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int unsigned SER_BITS = 16;
   // Fixed output patterns
   localparam logic [11:0] PAT_ZERO = 12'h000;
   localparam logic [11:0] PAT_ONES = 12'hfff;
   localparam logic [11:0] PAT_TOGGLE = 12'haaa;
   localparam logic [11:0] PAT_ALIGN = 12'haaa;
   localparam logic [11:0] PAT_SYNC = 12'hfc0;
   localparam logic [11:0] FMT_FLIP = 12'h800;

   typedef enum logic [2:0] {
      TP_NORMAL,
      TP_ZEROS,
      TP_ONES,
      TP_TOGGLE,
      TP_UNUSED,
      TP_CUSTOM,
      TP_ALIGN,
      TP_SYNC
   } acrb_pat_t;

   typedef enum logic [1:0] {
      SP_IDLE,
      SP_SHIFT,
      SP_SETTLE
   } acrb_sp_state_t;
endpackage : acrb_pkg

// *** design/acrb_regbank.sv ***
// Serial-programmed configuration register bank of a four-channel converter
`timescale 1ns/1ps
// Notes on behaviour
// - Hardware or software reset clears all bits
// - Bit 0 of 0x00: global power-down
// - Bits 1-4 power down channels A-D
// - Bit 5 selects external reference when set
// - Software reset bit self-clears after reset
// - Gain codes for steps 0,2-5 accepted
// - Gain code 00000 is step 1, default
// - Pattern code 000 passes converted samples
// - Code 011 gives toggle pattern
// - Code 101 gives 12-bit custom word
// - 110 alternating alignment stream, 111 sync
// - Bit 9 selects offset binary over two's complement
// - 0x0B bits 10-0 are pattern bits 10-0
// - 0x0C bit 0 is pattern bit 11
// - 0x0C bits 10-8 fine gain 0-6 dB; code 7 is passed to fine_gain_o unlimited
// - Write applies 100 ns after 16th clock
// - Pattern register lives at address 0x0a
module acrb_regbank #(
   parameter int unsigned NCH = 4
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic nrst_i,
   // Serial configuration pins
   input wire logic ser_clk_i,
   input wire logic ser_en_n_i,
   input wire logic ser_data_i,
   // Converted samples, one word per channel
   input wire logic [NCH*12-1:0] adc_sample_i,
   // Power and reference controls
   output logic global_pdn_o,
   output logic [NCH-1:0] ch_pdn_o,
   output logic ext_ref_o,
   // Analogue settings
   output logic [4:0] clk_gain_code_o,
   output logic [2:0] clk_gain_step_o,
   output logic [2:0] fine_gain_o,
   output logic output_number_format_o,
   // Output words, one per channel
   output logic [NCH*12-1:0] out_word_o
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [2:0] sclk_s;
      logic [1:0] sen_s;
      logic [1:0] sdat_s;
      acrb_pkg::acrb_sp_state_t st;
      logic [15:0] shreg;
      logic [4:0] bitcnt;
      logic [7:0] settle;
      logic [10:0] r_pwr;
      logic [10:0] r_clkg;
      logic [10:0] r_tpat;
      logic [10:0] r_cplo;
      logic [10:0] r_cphi;
      logic [NCH*12-1:0] word;
      logic [2:0] step;
      logic tgl;
   } acrb_state_t;

   localparam logic [7:0] SETTLE_LD = 8'(acrb_pkg::SETTLE_CYC);

   acrb_state_t s_q;
   acrb_state_t s_d;
   logic sclk_fall;
   logic [4:0] waddr;
   logic [10:0] wdata;
   logic [11:0] custom_pat;
   logic [11:0] pat_word;
   acrb_pkg::acrb_pat_t pat_sel;
   logic wr_land;

   assign sclk_fall = s_q.sclk_s[2] & ~s_q.sclk_s[1];
   // Frame: 5 address bits then 11 data bits gives 16 bits: a5 d11
   assign waddr = s_q.shreg[15:11];
   assign wdata = s_q.shreg[10:0];
   assign custom_pat = {s_q.r_cphi[acrb_pkg::CPHI_MSB_BIT], s_q.r_cplo};
   assign pat_sel = acrb_pkg::acrb_pat_t'(s_q.r_tpat[acrb_pkg::TPAT_SEL_LSB +: 3]);
   // Last settle cycle, on which a decoded frame writes its register
   assign wr_land = (s_q.st == acrb_pkg::SP_SETTLE) && (s_q.settle == 8'h01);

   always_comb begin
      case (pat_sel)
         acrb_pkg::TP_ZEROS: pat_word = acrb_pkg::PAT_ZERO;
         acrb_pkg::TP_ONES: pat_word = acrb_pkg::PAT_ONES;
         acrb_pkg::TP_TOGGLE: pat_word = s_q.tgl ? ~acrb_pkg::PAT_TOGGLE
                                                 : acrb_pkg::PAT_TOGGLE;
         acrb_pkg::TP_CUSTOM: pat_word = custom_pat;
         acrb_pkg::TP_ALIGN: pat_word = acrb_pkg::PAT_ALIGN;
         acrb_pkg::TP_SYNC: pat_word = acrb_pkg::PAT_SYNC;
         default: pat_word = acrb_pkg::PAT_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d = s_q;
      s_d.sclk_s = {s_q.sclk_s[1:0], ser_clk_i};
      s_d.sen_s = {s_q.sen_s[0], ser_en_n_i};
      s_d.sdat_s = {s_q.sdat_s[0], ser_data_i};
      s_d.tgl = ~s_q.tgl;
      case (s_q.st)
         acrb_pkg::SP_IDLE: begin
            s_d.bitcnt = 5'h00;
            if (!s_q.sen_s[1]) begin
               s_d.st = acrb_pkg::SP_SHIFT;
            end
         end
         acrb_pkg::SP_SHIFT: begin
            if (s_q.sen_s[1]) begin
               s_d.st = acrb_pkg::SP_IDLE;
            end else if (sclk_fall) begin
               s_d.shreg = {s_q.shreg[14:0], s_q.sdat_s[1]};
               s_d.bitcnt = s_q.bitcnt + 5'h01;
               if (s_q.bitcnt == 5'(acrb_pkg::SER_BITS - 1)) begin
                  s_d.settle = SETTLE_LD;
                  s_d.st = acrb_pkg::SP_SETTLE;
               end
            end
         end
         acrb_pkg::SP_SETTLE: begin
            s_d.settle = s_q.settle - 8'h01;
            if (s_q.settle == 8'h01) begin
               s_d.st = acrb_pkg::SP_IDLE;
               if (waddr == acrb_pkg::ADDR_PWR) begin
                  s_d.r_pwr = wdata & acrb_pkg::MASK_PWR;
               end else if (waddr == acrb_pkg::ADDR_CLKG) begin
                  s_d.r_clkg = wdata & acrb_pkg::MASK_CLKG;
               end else if (waddr == acrb_pkg::ADDR_TPAT) begin
                  s_d.r_tpat = wdata & acrb_pkg::MASK_TPAT;
               end else if (waddr == acrb_pkg::ADDR_CPLO) begin
                  s_d.r_cplo = wdata & acrb_pkg::MASK_CPLO;
               end else if (waddr == acrb_pkg::ADDR_CPHI) begin
                  s_d.r_cphi = wdata & acrb_pkg::MASK_CPHI;
               end
            end
         end
         default: s_d.st = acrb_pkg::SP_IDLE;
      endcase
      // Software reset clears the bank, itself included, next cycle
      if (s_q.r_pwr[acrb_pkg::PWR_SWRST_BIT]) begin
         s_d.r_pwr = acrb_pkg::REG_RST;
         s_d.r_clkg = acrb_pkg::REG_RST;
         s_d.r_tpat = acrb_pkg::REG_RST;
         s_d.r_cplo = acrb_pkg::REG_RST;
         s_d.r_cphi = acrb_pkg::REG_RST;
      end
      case (s_q.r_clkg[acrb_pkg::CLKG_LSB +: 5])
         acrb_pkg::CLKG_STEP0: s_d.step = 3'h0;
         acrb_pkg::CLKG_STEP2: s_d.step = 3'h2;
         acrb_pkg::CLKG_STEP3: s_d.step = 3'h3;
         acrb_pkg::CLKG_STEP4: s_d.step = 3'h4;
         acrb_pkg::CLKG_STEP5: s_d.step = 3'h5;
         default: s_d.step = 3'h1;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (pat_sel == acrb_pkg::TP_NORMAL) begin
            s_d.word[i*12 +: 12] = adc_sample_i[i*12 +: 12]
               ^ (s_q.r_tpat[acrb_pkg::TPAT_FMT_BIT] ? acrb_pkg::FMT_FLIP
                                                    : acrb_pkg::PAT_ZERO);
         end else begin
            s_d.word[i*12 +: 12] = pat_word;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
         s_q.sen_s <= 2'h3;
         s_q.step <= 3'h1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign global_pdn_o = s_q.r_pwr[acrb_pkg::PWR_GLOBAL_BIT];
   assign ch_pdn_o = s_q.r_pwr[acrb_pkg::PWR_CH_LSB +: NCH];
   assign ext_ref_o = s_q.r_pwr[acrb_pkg::PWR_REF_BIT];
   assign clk_gain_code_o = s_q.r_clkg[acrb_pkg::CLKG_LSB +: 5];
   assign clk_gain_step_o = s_q.step;
   assign fine_gain_o = s_q.r_cphi[acrb_pkg::CPHI_FG_LSB +: 3];
   assign output_number_format_o = s_q.r_tpat[acrb_pkg::TPAT_FMT_BIT];
   assign out_word_o = s_q.word;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_swrst_clear;
      @(posedge mclk_i) disable iff (!nrst_i)
      s_q.r_pwr[acrb_pkg::PWR_SWRST_BIT] |=> (s_q.r_pwr == 11'h000 && s_q.r_cplo == 11'h000);
   endproperty
   a_swrst_clear: assert property (p_swrst_clear) else $error("software reset did not clear");

   property p_glob;
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_land && waddr == acrb_pkg::ADDR_PWR)
         |=> global_pdn_o == $past(wdata[acrb_pkg::PWR_GLOBAL_BIT]);
   endproperty
   a_glob: assert property (p_glob) else $error("global power-down mismatch");

   property p_ch;
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_land && waddr == acrb_pkg::ADDR_PWR)
         |=> ch_pdn_o == $past(wdata[acrb_pkg::PWR_CH_LSB +: NCH]);
   endproperty
   a_ch: assert property (p_ch) else $error("channel power-down mismatch");

   property p_ref;
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_land && waddr == acrb_pkg::ADDR_PWR)
         |=> ext_ref_o == $past(wdata[acrb_pkg::PWR_REF_BIT]);
   endproperty
   a_ref: assert property (p_ref) else $error("reference select mismatch");

   property p_step1;
      @(posedge mclk_i) disable iff (!nrst_i)
      (clk_gain_code_o == 5'h00) |=> (clk_gain_step_o == 3'h1 || $changed(clk_gain_code_o));
   endproperty
   a_step1: assert property (p_step1) else $error("gain code 0 not step 1");

   property p_step5;
      @(posedge mclk_i) disable iff (!nrst_i)
      (clk_gain_code_o == 5'h08) ##1 (clk_gain_code_o == 5'h08) |-> clk_gain_step_o == 3'h5;
   endproperty
   a_step5: assert property (p_step5) else $error("gain code 01000 not step 5");

   property p_zero;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel == acrb_pkg::TP_ZEROS) |=> (out_word_o[11:0] == 12'h000 || $changed(pat_sel));
   endproperty
   a_zero: assert property (p_zero) else $error("zeros pattern wrong");

   property p_custom;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel == acrb_pkg::TP_CUSTOM) ##1 (pat_sel == acrb_pkg::TP_CUSTOM)
         |-> out_word_o[11:0] == $past(custom_pat);
   endproperty
   a_custom: assert property (p_custom) else $error("custom pattern wrong");

   property p_rsvd;
      @(posedge mclk_i) disable iff (!nrst_i)
      (s_q.r_tpat[4:0] == 5'h00) && (s_q.r_cphi[7:1] == 7'h00) && (s_q.r_clkg[1:0] == 2'h0)
         && (s_q.r_pwr[9:6] == 4'h0) && (s_q.r_clkg[10:7] == 4'h0)
         && !s_q.r_tpat[10] && !s_q.r_tpat[8];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_settle;
      @(posedge mclk_i) disable iff (!nrst_i)
      (s_q.st == acrb_pkg::SP_SHIFT && s_d.st == acrb_pkg::SP_SETTLE)
         |=> (s_q.st == acrb_pkg::SP_SETTLE)[*2] ##1 (s_q.st == acrb_pkg::SP_IDLE);
   endproperty
   a_settle: assert property (p_settle) else $error("write settle time wrong");

   property p_step0;
      @(posedge mclk_i) disable iff (!nrst_i)
      (clk_gain_code_o == 5'h18) ##1 (clk_gain_code_o == 5'h18) |-> clk_gain_step_o == 3'h0;
   endproperty
   a_step0: assert property (p_step0) else $error("gain code 11000 not step 0");

   property p_ones;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel == acrb_pkg::TP_ONES) |=> (out_word_o[11:0] == 12'hfff || $changed(pat_sel));
   endproperty
   a_ones: assert property (p_ones) else $error("ones pattern wrong");

   property p_toggle;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel == acrb_pkg::TP_TOGGLE)[*3] |-> out_word_o[11:0] == ~$past(out_word_o[11:0]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle pattern did not alternate");

   property p_fmt;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel == acrb_pkg::TP_NORMAL && output_number_format_o)[*2]
         |-> out_word_o[11] == ~$past(adc_sample_i[11]);
   endproperty
   a_fmt: assert property (p_fmt) else $error("offset binary sign bit wrong");

   property p_fine;
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_land && waddr == acrb_pkg::ADDR_CPHI)
         |=> fine_gain_o == $past(wdata[acrb_pkg::CPHI_FG_LSB +: 3]);
   endproperty
   a_fine: assert property (p_fine) else $error("fine gain write lost");

   property p_tpat_addr;
      @(posedge mclk_i) disable iff (!nrst_i)
      (wr_land && waddr == acrb_pkg::ADDR_TPAT)
         |=> output_number_format_o == $past(wdata[acrb_pkg::TPAT_FMT_BIT]);
   endproperty
   a_tpat_addr: assert property (p_tpat_addr) else $error("format bit write lost");

   property p_chan;
      @(posedge mclk_i) disable iff (!nrst_i)
      (pat_sel != acrb_pkg::TP_NORMAL)[*2] |-> out_word_o[12 +: 12] == out_word_o[11:0];
   endproperty
   a_chan: assert property (p_chan) else $error("channels carry different patterns");

   c_write: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      s_q.st == acrb_pkg::SP_SETTLE ##1 s_q.st == acrb_pkg::SP_IDLE);
   c_swrst: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      s_q.r_pwr[acrb_pkg::PWR_SWRST_BIT]);
   c_custom: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      pat_sel == acrb_pkg::TP_CUSTOM);
   c_toggle: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      pat_sel == acrb_pkg::TP_TOGGLE);
   c_gain_max: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      clk_gain_step_o == 3'h5);

endmodule : acrb_regbank

// *** verification/acrb_ser_host.sv ***
// Behavioural host that shifts one configuration word per frame
`timescale 1ns/1ps
module acrb_ser_host (
   // Clock
   input wire logic mclk_i,
   // Request from the bench
   input wire logic req_i,
   input wire logic [15:0] word_i,
   output logic busy_o,
   // Serial configuration pins
   output logic ser_clk_o,
   output logic ser_en_n_o,
   output logic ser_data_o
);
   initial begin
      busy_o = 1'b0;
      ser_clk_o = 1'b1;
      ser_en_n_o = 1'b1;
      ser_data_o = 1'b0;
      forever begin
         @(posedge mclk_i);
         if (req_i) begin
            busy_o <= 1'b1;
            ser_en_n_o <= 1'b0;
            // Address first, most significant bit first; bench keeps reserved bits zero
            for (int i = 15; i >= 0; i--) begin
               ser_data_o <= word_i[i];
               repeat (4) @(posedge mclk_i);
               ser_clk_o <= 1'b0;
               repeat (4) @(posedge mclk_i);
               ser_clk_o <= 1'b1;
            end
            // Released line shows the inverse of the last bit
            ser_data_o <= ~word_i[0];
            repeat (4) @(posedge mclk_i);
            ser_en_n_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            busy_o <= 1'b0;
         end
      end
   end
endmodule : acrb_ser_host

// *** verification/tb_acrb_regbank.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_acrb_regbank;
   logic mclk_i, nrst_i, req, busy, sclk, sen_n, sdat;
   logic [15:0] word;
   logic [11:0] prev;
   logic [47:0] smp = 48'h9ab_678_345_012;
   logic [47:0] out_word_o;
   logic global_pdn_o, ext_ref_o, output_number_format_o;
   logic [3:0] ch_pdn_o;
   logic [4:0] clk_gain_code_o;
   logic [2:0] clk_gain_step_o, fine_gain_o;
   logic [11:0] pexp [8] = '{12'h000, 12'h000, 12'hfff, 12'h000, 12'h000, 12'hda5, 12'haaa,
                             12'hfc0};
   logic [4:0] gc [6] = '{5'h18, 5'h00, 5'h0c, 5'h0a, 5'h09, 5'h08};
   int err_total = 0;
   int checks_done = 0;
   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'b0;
      forever #25 mclk_i = ~mclk_i;
   end
   acrb_ser_host i_acrb_ser_host (.mclk_i(mclk_i), .req_i(req), .word_i(word), .busy_o(busy),
      .ser_clk_o(sclk), .ser_en_n_o(sen_n), .ser_data_o(sdat));
   acrb_regbank #(.NCH(4)) i_acrb_regbank (.mclk_i(mclk_i), .nrst_i(nrst_i),
      .ser_clk_i(sclk), .ser_en_n_i(sen_n), .ser_data_i(sdat), .adc_sample_i(smp),
      .global_pdn_o(global_pdn_o), .ch_pdn_o(ch_pdn_o), .ext_ref_o(ext_ref_o),
      .clk_gain_code_o(clk_gain_code_o), .clk_gain_step_o(clk_gain_step_o),
      .fine_gain_o(fine_gain_o), .output_number_format_o(output_number_format_o),
      .out_word_o(out_word_o));
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   // One serial write, then wait out the settle time
   task automatic wr(input logic [4:0] a, input logic [10:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      req <= 1'b1;
      word <= {a, d};
      do @(posedge mclk_i); while (busy !== 1'b1 && n++ < 10);
      if (busy !== 1'b1) err_total++;
      req <= 1'b0;
      n = 0;
      while (busy !== 1'b0 && n++ < 300) @(posedge mclk_i);
      if (n >= 300) err_total++;
      repeat (8) @(posedge mclk_i);
      #1;
   endtask : wr
   task automatic hw_reset();
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask : hw_reset
   task automatic chk_clear();
      `CHK({global_pdn_o, ch_pdn_o, ext_ref_o, fine_gain_o, output_number_format_o}, 10'h0)
      `CHK(clk_gain_code_o, 5'h00)
      `CHK(clk_gain_step_o, 3'h1)
   endtask : chk_clear
   ////////////////////////////////////////////////////////////////////////
   initial begin
      nrst_i = 1'b0;
      req = 1'b0;
      word = 16'h0000;
      hw_reset();
      chk_clear();
      wr(acrb_pkg::ADDR_PWR, 11'h03f);
      `CHK({global_pdn_o, ch_pdn_o, ext_ref_o}, 6'h3f)
      wr(acrb_pkg::ADDR_PWR, 11'h02a);
      `CHK({global_pdn_o, ch_pdn_o, ext_ref_o}, 6'h0b)
      wr(5'h0d, 11'h4f7);
      `CHK({global_pdn_o, ch_pdn_o, ext_ref_o, output_number_format_o}, 7'h16)
      for (int i = 0; i < 6; i++) begin
         wr(acrb_pkg::ADDR_CLKG, 11'(gc[i]) << 2);
         `CHK(clk_gain_code_o, gc[i])
         @(posedge mclk_i);
         #1;
         `CHK(clk_gain_step_o, 3'(i))
      end
      for (int g = 0; g < 7; g++) begin
         wr(acrb_pkg::ADDR_CPHI, {3'(g), 8'h01});
         `CHK(fine_gain_o, 3'(g))
      end
      wr(acrb_pkg::ADDR_CPLO, 11'h5a5);
      for (int c = 0; c < 8; c++) begin
         wr(acrb_pkg::ADDR_TPAT, 11'(c) << 5);
         if (c == 3) begin
            prev = out_word_o[11:0];
            @(posedge mclk_i);
            #1;
            `CHK(out_word_o[11:0] ^ prev, 12'hfff)
            `CHK(out_word_o[23:12], out_word_o[11:0])
         end else begin
            `CHK(out_word_o, c == 0 ? smp : {4{pexp[c]}})
         end
      end
      wr(acrb_pkg::ADDR_TPAT, 11'h200);
      `CHK(output_number_format_o, 1'b1)
      `CHK(out_word_o[11:0], smp[11:0] ^ 12'h800)
      wr(acrb_pkg::ADDR_PWR, 11'h400);
      chk_clear();
      `CHK(out_word_o, smp)
      wr(acrb_pkg::ADDR_PWR, 11'h002);
      `CHK(ch_pdn_o, 4'h1)
      hw_reset();
      chk_clear();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      err_total++;
      test_done();
   end
endmodule : tb_acrb_regbank
